// file: hw/peripheral_auto_powerdown.sv
`timescale 1ns/1ps
module peripheral_auto_powerdown
    import pm_pkg::*;
#(
    parameter int APD_COUNT = APD_CYCLES
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic i_host_read_strobe_n,
    input wire logic i_host_write_strobe_n,
    input wire logic i_fdc_select,
    input wire logic [2:0] i_system_address_bus,
    input wire logic [7:0] i_system_data_bus,
    input wire logic i_bus_reset_in,
    input wire logic [7:0] i_auto_power_config,
    input wire logic [7:0] i_direct_power_control,
    input wire logic [7:0] i_status_a,
    input wire logic [7:0] i_status_b,
    input wire logic [7:0] i_digital_input,
    input wire logic [7:0] i_main_status,
    input wire logic i_fdc_interrupt,
    input wire logic i_fdc_dma_request,
    input wire logic i_head_unloaded,
    input wire logic i_head_direction_n,
    input wire logic i_head_step_n,
    input wire logic i_write_data_n,
    input wire logic i_write_gate_n,
    input wire logic i_head_select_n,
    input wire logic [1:0] i_density_select,
    input wire logic [1:0] i_drive_select_n,
    input wire logic [1:0] i_tx_empty,
    input wire logic [1:0] i_rx_idle,
    input wire logic [1:0] i_transmit_buffer_write,
    input wire logic [1:0] i_serial_receive_in,
    input wire logic [1:0] i_ring_indicator_in,
    input wire logic i_epp_enabled,
    input wire logic i_ecp_enabled,
    input wire logic [2:0] i_ecr_mode,
    output logic [7:0] O_SYSTEM_DATA_BUS,
    output logic O_SYSTEM_DATA_OE,
    output logic O_INTERRUPT_REQUEST_OUT,
    output logic O_DMA_REQUEST_OUT,
    output logic [7:0] O_DIGITAL_OUTPUT,
    output logic [7:0] O_DATA_RATE_SELECT,
    output logic [7:0] O_CONFIG_CONTROL,
    output logic O_FDC_POWERDOWN,
    output logic O_FDC_WAKE,
    output logic [1:0] O_MOTOR_ON_N,
    output logic [1:0] O_MOTOR_ON_OE,
    output logic [1:0] O_DRIVE_SELECT_N,
    output logic [1:0] O_DRIVE_SELECT_OE,
    output logic O_WRITE_DATA_N,
    output logic O_WRITE_DATA_OE,
    output logic O_WRITE_GATE_N,
    output logic O_WRITE_GATE_OE,
    output logic O_HEAD_DIRECTION_N,
    output logic O_HEAD_STEP_N,
    output logic O_HEAD_SELECT_N,
    output logic [1:0] O_DENSITY_SELECT,
    output logic [1:0] O_TX_POWERDOWN,
    output logic [1:0] O_RX_POWERDOWN,
    output logic [1:0] O_RING_INTERRUPT,
    output logic O_EPP_POWERDOWN,
    output logic O_ECP_POWERDOWN
);

    // ============================================================
    // State
    // ============================================================
    typedef struct packed {
        logic [1:0] rd_s1;          // Read strobe sync stage 1
        logic [1:0] rd_s2;          // Read strobe sync stage 2
        logic [1:0] wr_s1;          // Write strobe sync stage 1
        logic [1:0] wr_s2;          // Write strobe sync stage 2 and delayed
        logic [1:0] bres_s;         // Bus reset sync
        logic [3:0] rxd_s1;         // Receive data sync stage 1
        logic [3:0] rxd_s2;         // Receive data sync stage 2 and delayed
        logic [3:0] ri_s1;          // Ring indicator sync stage 1
        logic [3:0] ri_s2;          // Ring indicator sync stage 2 and delayed
        logic [7:0] digital_output;            // Digital output register
        logic [7:0] dsr;            // Data rate select register
        logic [7:0] config_control;            // Configuration control register
        logic [31:0] apd_cnt;       // Auto powerdown timer
        logic fdc_pd;               // Floppy in auto powerdown
        logic fdc_wake;             // Wake pulse
        logic [7:0] rdata;          // Read data
        logic rd_oe;                // Read drive enable
        logic irq;
        logic drq;
        logic [1:0] mtr_n;
        logic [1:0] ds_n;
        logic wdata_n;
        logic wgate_n;
        logic dir_n;
        logic step_n;
        logic hdsel_n;
        logic [1:0] densel;
        logic drives_off;           // Drive pins tristated
        logic [1:0] tx_pd;
        logic [1:0] rx_pd;
        logic [1:0] ring_int;
        logic epp_pd;
        logic ecp_pd;
    } state_type;

    state_type s;       // Registered state
    state_type next_s;  // Next state

    // Access decode shared by read and write paths
    function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
        hit = (a == ofs);
    endfunction

    // ============================================================
    // Next-state logic
    // ============================================================
    always_comb begin
        logic rd_edge;      // Read strobe falling, synced
        logic wr_done;      // Write strobe rising, synced
        logic rd_low;       // Read in progress
        logic wake_req;     // Access demands wake
        logic sw_reset;     // Software reset via write
        logic idle_ok;      // Floppy entry conditions
        logic [1:0] u_en;   // Serial auto powerdown enables
        logic [7:0] wd;     // Written byte
        rd_edge = 1'b0;
        wr_done = 1'b0;
        rd_low = 1'b0;
        wake_req = 1'b0;
        sw_reset = 1'b0;
        idle_ok = 1'b0;
        u_en = 2'b00;
        wd = i_system_data_bus;
        next_s = s;

        // Synchronisers for pins, second stage read only
        next_s.rd_s1 = {s.rd_s1[0], ~i_host_read_strobe_n};
        next_s.rd_s2 = {s.rd_s2[0], s.rd_s1[1]};
        next_s.wr_s1 = {s.wr_s1[0], ~i_host_write_strobe_n};
        next_s.wr_s2 = {s.wr_s2[0], s.wr_s1[1]};
        next_s.bres_s = {s.bres_s[0], i_bus_reset_in};
        next_s.rxd_s1 = {s.rxd_s1[1:0], i_serial_receive_in};
        next_s.rxd_s2 = {s.rxd_s2[1:0], s.rxd_s1[3:2]};
        next_s.ri_s1 = {s.ri_s1[1:0], i_ring_indicator_in};
        next_s.ri_s2 = {s.ri_s2[1:0], s.ri_s1[3:2]};

        rd_low = s.rd_s2[0] & i_fdc_select;
        rd_edge = s.rd_s2[0] & ~s.rd_s2[1] & i_fdc_select;
        wr_done = ~s.wr_s2[0] & s.wr_s2[1] & i_fdc_select;
        next_s.fdc_wake = 1'b0;

        // true status on reads regardless of sleep
        next_s.rd_oe = rd_low;
        case (i_system_address_bus)
            OFS_STATUS_A: next_s.rdata = i_status_a;
            OFS_STATUS_B: next_s.rdata = i_status_b;
            OFS_DIGITAL_OUTPUT: next_s.rdata = s.digital_output;
            OFS_MAIN_STATUS: next_s.rdata = i_main_status;
            OFS_DIGITAL_INPUT: next_s.rdata = i_digital_input;
            default: next_s.rdata = 8'h00;
        endcase

        if (wr_done) begin
            if (hit(i_system_address_bus, OFS_DIGITAL_OUTPUT)) begin
                next_s.digital_output = wd;
                if (wd[DOR_MOTOR_LSB +: 4] != 4'h0 || !wd[DOR_RESET_N_BIT]) begin
                    wake_req = 1'b1;
                end
                sw_reset = ~wd[DOR_RESET_N_BIT];
            end
            if (hit(i_system_address_bus, OFS_DATA_RATE_SELECT)) begin
                next_s.dsr = wd;
                if (wd[DSR_SWRESET_BIT]) begin
                    wake_req = 1'b1;
                end
                sw_reset = wd[DSR_SWRESET_BIT];
            end
            if (hit(i_system_address_bus, OFS_CONFIG_CONTROL)) begin
                next_s.config_control = wd;
            end
            if (hit(i_system_address_bus, OFS_DATA_FIFO_PORT)) begin
                wake_req = 1'b1;
            end
        end
        // main status or data read wakes
        if (rd_edge && (hit(i_system_address_bus, OFS_MAIN_STATUS)
                || hit(i_system_address_bus, OFS_DATA_FIFO_PORT))) begin
            wake_req = 1'b1;
        end
        if (sw_reset) begin
            wake_req = 1'b1;
        end

        idle_ok = (s.digital_output[DOR_MOTOR_LSB +: 4] == 4'h0) && (i_main_status == MAIN_STATUS_IDLE)
            && !i_fdc_interrupt && i_head_unloaded;

        if (!i_auto_power_config[APC_FDC_BIT]) begin
            next_s.apd_cnt = 32'h0;
            next_s.fdc_pd = 1'b0;
        end else if (wake_req || s.bres_s[1]) begin
            next_s.apd_cnt = 32'h0;
            next_s.fdc_pd = 1'b0;
            next_s.fdc_wake = s.fdc_pd;
        end else if (!s.fdc_pd) begin
            if (s.apd_cnt < 32'(APD_COUNT)) begin
                next_s.apd_cnt = s.apd_cnt + 32'h1;
            end else if (idle_ok) begin
                // sleep once timer expired and idle
                next_s.fdc_pd = 1'b1;
            end
        end
        // non-waking access leaves sleep state set

        // requests low while asleep, bus stays live
        next_s.irq = next_s.fdc_pd ? 1'b0 : i_fdc_interrupt;
        next_s.drq = next_s.fdc_pd ? 1'b0 : i_fdc_dma_request;

        // direct powerdown bit 0 also tristates drive
        next_s.drives_off = next_s.fdc_pd | ~i_direct_power_control[APC_FDC_BIT];
        // motor, select, write pins tristated asleep
        next_s.mtr_n = ~s.digital_output[DOR_MOTOR_LSB +: 2];
        next_s.ds_n = i_drive_select_n;
        next_s.wdata_n = i_write_data_n;
        next_s.wgate_n = i_write_gate_n;
        next_s.dir_n = i_head_direction_n;
        next_s.step_n = i_head_step_n;
        next_s.hdsel_n = i_head_select_n;
        next_s.densel = i_density_select;

        u_en = {i_auto_power_config[APC_UART2_BIT], i_auto_power_config[APC_UART1_BIT]};
        for (int k = 0; k < 2; k++) begin
            if (!u_en[k]) begin
                next_s.tx_pd[k] = 1'b0;
                next_s.rx_pd[k] = 1'b0;
            end else begin
                if (i_transmit_buffer_write[k]) begin
                    next_s.tx_pd[k] = 1'b0;
                end else if (i_tx_empty[k]) begin
                    next_s.tx_pd[k] = 1'b1;
                end
                if (s.rxd_s2[k] != s.rxd_s2[k + 2]) begin
                    next_s.rx_pd[k] = 1'b0;
                end else if (i_rx_idle[k]) begin
                    next_s.rx_pd[k] = 1'b1;
                end
            end
            if (!i_direct_power_control[k + APC_UART1_BIT]) begin
                next_s.tx_pd[k] = 1'b1;
                next_s.rx_pd[k] = 1'b1;
            end
            next_s.ring_int[k] = s.ri_s2[k] != s.ri_s2[k + 2];
        end

        // parallel state evaluated from live mode each cycle
        if (!i_auto_power_config[APC_PAR_BIT]) begin
            next_s.epp_pd = 1'b0;
            next_s.ecp_pd = 1'b0;
        end else begin
            // EPP off unless enabled and, when ECP is enabled, selected in ecr mode
            next_s.epp_pd = !i_epp_enabled || (i_ecp_enabled && i_ecr_mode != ECR_EPP);
            // ECP off in standard, byte or EPP mode
            next_s.ecp_pd = !i_ecp_enabled || i_ecr_mode == ECR_SPP || i_ecr_mode == ECR_BIDIR
                || i_ecr_mode == ECR_EPP;
        end
        if (!i_direct_power_control[APC_PAR_BIT]) begin
            next_s.epp_pd = 1'b1;
            next_s.ecp_pd = 1'b1;
        end
    end

    // ============================================================
    // State register
    // ============================================================
    // register contents held only by reset, no battery domain here
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            s <= '0;
            s.digital_output <= DOR_RESET;
            s.dsr <= DSR_RESET;
            s.config_control <= CCR_RESET;
            s.mtr_n <= 2'h3;
            s.ds_n <= 2'h3;
            s.wdata_n <= 1'b1;
            s.wgate_n <= 1'b1;
            s.dir_n <= 1'b1;
            s.step_n <= 1'b1;
            s.hdsel_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    assign O_SYSTEM_DATA_BUS = s.rdata;
    assign O_SYSTEM_DATA_OE = s.rd_oe;
    assign O_INTERRUPT_REQUEST_OUT = s.irq;
    assign O_DMA_REQUEST_OUT = s.drq;
    assign O_DIGITAL_OUTPUT = s.digital_output;
    assign O_DATA_RATE_SELECT = s.dsr;
    assign O_CONFIG_CONTROL = s.config_control;
    assign O_FDC_POWERDOWN = s.fdc_pd;
    assign O_FDC_WAKE = s.fdc_wake;
    assign O_MOTOR_ON_N = s.mtr_n;
    assign O_MOTOR_ON_OE = {2{~s.drives_off}};
    assign O_DRIVE_SELECT_N = s.ds_n;
    assign O_DRIVE_SELECT_OE = {2{~s.drives_off}};
    assign O_WRITE_DATA_N = s.wdata_n;
    assign O_WRITE_DATA_OE = ~s.drives_off;
    assign O_WRITE_GATE_N = s.wgate_n;
    assign O_WRITE_GATE_OE = ~s.drives_off;
    assign O_HEAD_DIRECTION_N = s.dir_n;
    assign O_HEAD_STEP_N = s.step_n;
    assign O_HEAD_SELECT_N = s.hdsel_n;
    assign O_DENSITY_SELECT = s.densel;
    assign O_TX_POWERDOWN = s.tx_pd;
    assign O_RX_POWERDOWN = s.rx_pd;
    assign O_RING_INTERRUPT = s.ring_int;
    assign O_EPP_POWERDOWN = s.epp_pd;
    assign O_ECP_POWERDOWN = s.ecp_pd;

endmodule

// file: hw/pm_pkg.sv
package pm_pkg;
    // Floppy host register offsets (low three address bits)
    localparam logic [2:0] OFS_STATUS_A = 3'h0;
    localparam logic [2:0] OFS_STATUS_B = 3'h1;
    localparam logic [2:0] OFS_DIGITAL_OUTPUT = 3'h2;
    localparam logic [2:0] OFS_DATA_RATE_SELECT = 3'h4;
    localparam logic [2:0] OFS_MAIN_STATUS = 3'h4;
    localparam logic [2:0] OFS_DATA_FIFO_PORT = 3'h5;
    localparam logic [2:0] OFS_DIGITAL_INPUT = 3'h7;
    localparam logic [2:0] OFS_CONFIG_CONTROL = 3'h7;
    // Field positions
    localparam int DOR_RESET_N_BIT = 2;
    localparam int DOR_MOTOR_LSB = 4;
    localparam int DSR_SWRESET_BIT = 7;
    localparam int APC_FDC_BIT = 0;
    localparam int APC_PAR_BIT = 3;
    localparam int APC_UART1_BIT = 4;
    localparam int APC_UART2_BIT = 5;
    // Reset values and main status idle value
    localparam logic [7:0] DOR_RESET = 8'h00;
    localparam logic [7:0] DSR_RESET = 8'h02;
    localparam logic [7:0] CCR_RESET = 8'h02;
    localparam logic [7:0] APC_RESET = 8'h00;
    localparam logic [7:0] MAIN_STATUS_IDLE = 8'h80;
    // Extended control mode codes (ecr bits 7:5)
    localparam logic [2:0] ECR_SPP = 3'h0;
    localparam logic [2:0] ECR_BIDIR = 3'h1;
    localparam logic [2:0] ECR_EPP = 3'h4;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int APD_TIME_MS = 10;
    localparam int APD_CYCLES = APD_TIME_MS * 1000 * CLK_MHZ;
endpackage

// file: verif/host_bus_model.sv
`timescale 1ns/1ps
// ==========================================
// Host side of the floppy register bus
module host_bus_model (
    input wire logic i_clk,
    input wire logic [7:0] i_read_data,
    output logic o_read_n = 1'b1,
    output logic o_write_n = 1'b1,
    output logic o_select = 1'b0,
    output logic [2:0] o_addr = 3'h0,
    output logic [7:0] o_data = 8'h00
);
    // Write: strobe low four cycles, address held past the rise
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk) #1;
        o_select = 1'b1;
        o_addr = a;
        o_data = d;
        o_write_n = 1'b0;
        repeat (4) @(posedge i_clk);
        #1 o_write_n = 1'b1;
        repeat (4) @(posedge i_clk);
        #1 o_select = 1'b0;
        o_data = ~d;
    endtask
    // Read: data sampled once the sync lag has passed
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk) #1;
        o_select = 1'b1;
        o_addr = a;
        o_read_n = 1'b0;
        repeat (5) @(posedge i_clk);
        #1;
        d = i_read_data;
        o_read_n = 1'b1;
        repeat (4) @(posedge i_clk);
        #1 o_select = 1'b0;
    endtask
endmodule

// file: verif/pad_checker.sv
`timescale 1ns/1ps
// ==========================================
// Power state checker at the top ports
module pad_checker
    import pm_pkg::*;
#(
    parameter int APD_COUNT = APD_CYCLES
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic [7:0] i_auto_power_config,
    input wire logic [7:0] i_direct_power_control,
    input wire logic [7:0] i_main_status,
    input wire logic i_epp_enabled,
    input wire logic i_ecp_enabled,
    input wire logic [2:0] i_ecr_mode,
    input wire logic O_INTERRUPT_REQUEST_OUT,
    input wire logic O_DMA_REQUEST_OUT,
    input wire logic [7:0] O_DIGITAL_OUTPUT,
    input wire logic O_FDC_POWERDOWN,
    input wire logic O_FDC_WAKE,
    input wire logic [1:0] O_MOTOR_ON_OE,
    input wire logic [1:0] O_DRIVE_SELECT_OE,
    input wire logic O_WRITE_DATA_OE,
    input wire logic O_WRITE_GATE_OE,
    input wire logic O_EPP_POWERDOWN,
    input wire logic O_ECP_POWERDOWN,
    input wire logic [1:0] O_TX_POWERDOWN
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    // Host requests stay low while asleep
    a_irq_held_low: assert property (O_FDC_POWERDOWN && $past(O_FDC_POWERDOWN) |-> !O_INTERRUPT_REQUEST_OUT)
        else $error("irq active asleep");
    a_dma_held_low: assert property (O_FDC_POWERDOWN && $past(O_FDC_POWERDOWN) |-> !O_DMA_REQUEST_OUT)
        else $error("dma active asleep");
    a_drive_pins_float: assert property (O_FDC_POWERDOWN && $past(O_FDC_POWERDOWN)
        |-> !(|{O_MOTOR_ON_OE, O_DRIVE_SELECT_OE, O_WRITE_DATA_OE, O_WRITE_GATE_OE})) else $error("drive pin driven");
    // Wake is a single pulse leaving sleep
    a_wake_one_pulse: assert property (O_FDC_WAKE |=> !O_FDC_WAKE)
        else $error("wake pulse too long");
    a_wake_from_sleep: assert property (O_FDC_WAKE |-> $past(O_FDC_POWERDOWN) && !O_FDC_POWERDOWN)
        else $error("wake without sleep");
    a_sleep_needs_idle: assert property ($rose(O_FDC_POWERDOWN)
        |-> $past(i_main_status) == MAIN_STATUS_IDLE && O_DIGITAL_OUTPUT[7:4] == 4'h0) else $error("sleep not idle");
    a_disable_holds_awake: assert property (!$past(i_auto_power_config[APC_FDC_BIT]) |-> !O_FDC_POWERDOWN)
        else $error("asleep while disabled");
    // Parallel logic follows mode and enables
    // First edge after reset skipped: past inputs were sampled while the state was held in reset
    a_epp_not_enabled: assert property (!$past(I_RST) && $past(i_auto_power_config[APC_PAR_BIT] && !i_epp_enabled)
        |-> O_EPP_POWERDOWN) else $error("epp awake");
    a_ecp_mode_sleep: assert property (!$past(I_RST) && $past(i_auto_power_config[APC_PAR_BIT]
        && (!i_ecp_enabled || i_ecr_mode == ECR_SPP || i_ecr_mode == ECR_BIDIR || i_ecr_mode == ECR_EPP))
        |-> O_ECP_POWERDOWN) else $error("ecp awake");
    a_par_disable_up: assert property ($past(!i_auto_power_config[APC_PAR_BIT] && i_direct_power_control[APC_PAR_BIT])
        |-> !O_EPP_POWERDOWN && !O_ECP_POWERDOWN) else $error("parallel asleep");
    a_direct_par_down: assert property (!$past(I_RST) && $past(!i_direct_power_control[APC_PAR_BIT])
        |-> O_EPP_POWERDOWN && O_ECP_POWERDOWN) else $error("parallel awake");
    a_serial_disable_up: assert property ($past(!i_auto_power_config[APC_UART1_BIT])
        && $past(i_direct_power_control[APC_UART1_BIT]) |-> !O_TX_POWERDOWN[0]) else $error("serial asleep");
endmodule

bind peripheral_auto_powerdown pad_checker #(.APD_COUNT(APD_COUNT)) chk (.I_MCLK, .I_RST, .i_auto_power_config,
    .i_direct_power_control, .i_main_status, .i_epp_enabled, .i_ecp_enabled, .i_ecr_mode, .O_INTERRUPT_REQUEST_OUT,
    .O_DMA_REQUEST_OUT, .O_DIGITAL_OUTPUT, .O_FDC_POWERDOWN, .O_FDC_WAKE, .O_MOTOR_ON_OE, .O_DRIVE_SELECT_OE,
    .O_WRITE_DATA_OE, .O_WRITE_GATE_OE, .O_EPP_POWERDOWN, .O_ECP_POWERDOWN, .O_TX_POWERDOWN);

// file: verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
`define WAITC(c) begin int k; for (k = 0; k < 60 && !(c); k++) begin @(posedge I_MCLK); #1; end end
module tb_top;
    import pm_pkg::*;
    localparam int APD = 20;
    logic I_MCLK = 1'b0;
    logic I_RST = 1'b1;
    int err_count = 0;
    int cmp_count = 0;
    int seed = 21393;
    int wk = 0;
    int oec = 0;
    int i;
    logic rd_n, wr_n, sel;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rv, ev, dorv, dsrv, ccrv;
    logic [7:0] apc = 8'h39;
    logic [7:0] dpc = 8'hFF;
    logic [7:0] ms = MAIN_STATUS_IDLE;
    logic [7:0] st [3] = '{8'h00, 8'h00, 8'h00};
    logic [2:0] rofs [3] = '{OFS_STATUS_A, OFS_STATUS_B, OFS_DIGITAL_INPUT};
    logic [2:0] wofs [6] = '{OFS_MAIN_STATUS, OFS_DATA_FIFO_PORT, OFS_DATA_FIFO_PORT, OFS_DIGITAL_OUTPUT,
        OFS_DIGITAL_OUTPUT, OFS_DATA_RATE_SELECT};
    logic [7:0] wdat [6] = '{8'h00, 8'h00, 8'h5A, 8'h14, 8'h00, 8'h80};
    logic irq = 1'b0, dmar = 1'b0, unl = 1'b1, eppe = 1'b1, ecpe = 1'b1;
    logic [8:0] drv = 9'h1FF;
    logic [1:0] txe = 2'b11, rxi = 2'b11, tbw = 2'b00, rxd = 2'b11, ri = 2'b00;
    logic [2:0] ecr = ECR_EPP;
    logic fpd, fwake, epd, cpd, doe;
    logic bres = 1'b0;
    logic [1:0] txpd, rxpd, ring, mtrn, moe, e;
    wire [8:0] dout;
    logic [7:0] digital_output, dsr, config_control;
    // Clock at 100 MHz
    initial forever #5 I_MCLK = ~I_MCLK;
    // Count wake pulses
    always @(posedge I_MCLK) if (fwake === 1'b1) wk++;
    // Count cycles with read data driven
    always @(posedge I_MCLK) if (doe === 1'b1) oec++;
    host_bus_model host (.i_clk(I_MCLK), .i_read_data(rdata), .o_read_n(rd_n), .o_write_n(wr_n), .o_select(sel),
        .o_addr(addr), .o_data(wdata));
    peripheral_auto_powerdown #(.APD_COUNT(APD)) dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .i_host_read_strobe_n(rd_n),
        .i_host_write_strobe_n(wr_n), .i_fdc_select(sel), .i_system_address_bus(addr), .i_system_data_bus(wdata),
        .i_bus_reset_in(bres), .i_auto_power_config(apc), .i_direct_power_control(dpc), .i_status_a(st[0]),
        .i_status_b(st[1]), .i_digital_input(st[2]), .i_main_status(ms), .i_fdc_interrupt(irq),
        .i_fdc_dma_request(dmar), .i_head_unloaded(unl), .i_head_direction_n(drv[8]), .i_head_step_n(drv[7]),
        .i_write_data_n(drv[6]), .i_write_gate_n(drv[5]), .i_head_select_n(drv[4]), .i_density_select(drv[3:2]),
        .i_drive_select_n(drv[1:0]), .i_tx_empty(txe), .i_rx_idle(rxi), .i_transmit_buffer_write(tbw),
        .i_serial_receive_in(rxd), .i_ring_indicator_in(ri), .i_epp_enabled(eppe), .i_ecp_enabled(ecpe),
        .i_ecr_mode(ecr), .O_SYSTEM_DATA_BUS(rdata), .O_SYSTEM_DATA_OE(doe), .O_INTERRUPT_REQUEST_OUT(),
        .O_DMA_REQUEST_OUT(), .O_DIGITAL_OUTPUT(digital_output), .O_DATA_RATE_SELECT(dsr), .O_CONFIG_CONTROL(config_control),
        .O_FDC_POWERDOWN(fpd), .O_FDC_WAKE(fwake), .O_MOTOR_ON_N(mtrn), .O_MOTOR_ON_OE(moe),
        .O_DRIVE_SELECT_N(dout[1:0]), .O_DRIVE_SELECT_OE(), .O_WRITE_DATA_N(dout[6]), .O_WRITE_DATA_OE(),
        .O_WRITE_GATE_N(dout[5]), .O_WRITE_GATE_OE(), .O_HEAD_DIRECTION_N(dout[8]), .O_HEAD_STEP_N(dout[7]),
        .O_HEAD_SELECT_N(dout[4]), .O_DENSITY_SELECT(dout[3:2]),
        .O_TX_POWERDOWN(txpd), .O_RX_POWERDOWN(rxpd), .O_RING_INTERRUPT(ring), .O_EPP_POWERDOWN(epd),
        .O_ECP_POWERDOWN(cpd));
    // Expected parallel sleep state: {epp, ecp}
    function automatic logic [1:0] par_exp(input logic en, input logic up, input logic ep, input logic ec,
        input logic [2:0] m);
        if (!up) return 2'b11;
        if (!en) return 2'b00;
        return {!ep || (ec && m != ECR_EPP), !ec || m == ECR_SPP || m == ECR_BIDIR || m == ECR_EPP};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge I_MCLK);
        #1;
    endtask
    // Wait for floppy sleep
    task automatic nap();
        `WAITC(fpd === 1'b1)
        `CHK(fpd, 1'b1)
    endtask
    task automatic summarize();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        tick(10);
        I_RST = 1'b0;
        nap();
        // Non-waking reads and writes while asleep
        foreach (st[j]) st[j] = 8'($random(seed));
        dmar = 1'b1;
        irq = 1'b1;
        foreach (st[j]) begin
            oec = 0;
            host.rd(rofs[j], rv);
            `CHK(rv, st[j])
            `CHK(oec, 5)
            `CHK(fpd, 1'b1)
        end
        dorv = 8'($random(seed)) & 8'h0B | 8'h04;
        dsrv = 8'($random(seed)) & 8'h7F;
        ccrv = 8'($random(seed));
        wk = 0;
        host.wr(OFS_DIGITAL_OUTPUT, dorv);
        host.wr(OFS_DATA_RATE_SELECT, dsrv);
        host.wr(OFS_CONFIG_CONTROL, ccrv);
        `CHK({digital_output, dsr, config_control}, {dorv, dsrv, ccrv})
        `CHK(fpd, 1'b1)
        `CHK(wk, 0)
        // Waking accesses, then sleep again
        irq = 1'b0;
        for (i = 0; i < 6; i++) begin
            nap();
            wk = 0;
            if (i < 2) host.rd(wofs[i], rv);
            else host.wr(wofs[i], wdat[i]);
            tick(1);
            `CHK(fpd, 1'b0)
            `CHK(wk, 1)
            if (i == 0) `CHK(rv, ms)
            if (i == 3) `CHK(mtrn, 2'b10)
            if (i > 2) host.wr(OFS_DIGITAL_OUTPUT, 8'h04);
        end
        // Drive pins while asleep, then direct powerdown
        nap();
        drv = 9'($random(seed));
        tick(2);
        `CHK(dout, drv)
        // Bus reset pin stays live and wakes the floppy
        wk = 0;
        bres = 1'b1;
        tick(4);
        bres = 1'b0;
        `CHK(fpd, 1'b0)
        `CHK(wk, 1)
        apc[0] = 1'b0;
        tick(APD + 5);
        `CHK(fpd, 1'b0)
        `CHK(moe, 2'b11)
        dpc[0] = 1'b0;
        tick(2);
        `CHK(moe, 2'b00)
        dpc[0] = 1'b1;
        // Serial ports
        for (i = 0; i < 2; i++) begin
            `WAITC(txpd[i] === 1'b1 && rxpd[i] === 1'b1)
            `CHK({txpd[i], rxpd[i]}, 2'b11)
            ri[i] = ~ri[i];
            `WAITC(ring[i] === 1'b1)
            `CHK(ring[i], 1'b1)
            tbw[i] = 1'b1;
            txe[i] = 1'b0;
            tick(1);
            tbw[i] = 1'b0;
            tick(2);
            `CHK(txpd[i], 1'b0)
            rxd[i] = ~rxd[i];
            `WAITC(rxpd[i] === 1'b0)
            `CHK(rxpd[i], 1'b0)
            rxi[i] = 1'b0;
            tick(10);
            `CHK(rxpd[i], 1'b0)
            {txe[i], rxi[i]} = 2'b11;
            tick(10);
            `CHK({txpd[i], rxpd[i]}, 2'b11)
            apc[4 + i] = 1'b0;
            tick(2);
            `CHK({txpd[i], rxpd[i]}, 2'b00)
        end
        // Parallel port modes, random with enables
        for (i = 0; i < 32; i++) begin
            {apc[3], dpc[3], eppe, ecpe, ecr} = 7'($random(seed));
            tick(2);
            e = par_exp(apc[3], dpc[3], eppe, ecpe, ecr);
            `CHK(cpd, e[0])
            `CHK(epd, e[1])
        end
        summarize();
    end
    // Watchdog well past the expected run length
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule
